// file: logic/swt_defines.vh
// Register offsets, fields, reset values and timing for the watchdog
`ifndef SWT_DEFINES_VH
`define SWT_DEFINES_VH
`define SWT_OFF_CTRL 12'h000
`define SWT_OFF_KEY 12'h004
`define SWT_OFF_STAT 12'h008
`define SWT_OFF_MASK 12'h00c
`define SWT_CTRL_EN 0
`define SWT_CTRL_FRZ 1
`define SWT_CTRL_RSP_LO 2
`define SWT_CTRL_RSP_HI 3
`define SWT_CTRL_TOP_LO 4
`define SWT_CTRL_TOP_HI 6
`define SWT_CTRL_RST 7'h00
`define SWT_KEY_VALUE 16'ha5a5
`define SWT_RSP_FIQ 2'h0
`define SWT_RSP_SYSRST 2'h3
`define SWT_ST_FIRST 0
`define SWT_ST_SECOND 1
`define SWT_ST_RST 2'h0
`define SWT_MASK_RST 2'h0
`define SWT_RST_PULSE 8'h10
`endif

// file: logic/swt_watchdog.v
// Watchdog timer with APB register access
//
// The APB register port is this design's own decision.
`timescale 1ns/10ps
`include "swt_defines.vh"
module swt_watchdog
#(
   parameter CNT_W = 32,
   parameter RST_LEN = 8
)
(
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   output reg fast_interrupt_request,
   output reg sys_reset_req,
   output reg irq
);

   // ***************************************************
   // Registers
   // ***************************************************
   localparam [CNT_W-1:0] ONE_W = {{(CNT_W-1){1'b0}}, 1'b1};
   reg [6:0] ctrl_r;
   reg [6:0] ctrl_nxt;
   reg [CNT_W-1:0] cnt_r;
   reg [CNT_W-1:0] cnt_nxt;
   reg first_timeout_flag_r;
   reg first_timeout_flag_nxt;
   reg fiq_nxt;
   reg [1:0] stat_r;
   reg [1:0] mask_r;
   reg [1:0] mask_nxt;
   reg [7:0] rst_cnt_r;
   reg [7:0] rst_cnt_nxt;
   reg sys_reset_nxt;
   reg [CNT_W-1:0] limit;
   reg [31:0] rdata_nxt;
   reg addr_ok;
   wire [1:0] stat_set;
   wire [1:0] stat_clr;
   genvar gi;

   // ***************************************************
   // Bus phase decode
   // ***************************************************
   wire setup = psel & ~penable;
   wire access = psel & penable & pready;
   wire wr = access & pwrite;
   wire rd = setup & ~pwrite;
   wire wr_ctrl = wr & (paddr == `SWT_OFF_CTRL);
   wire wr_key = wr & (paddr == `SWT_OFF_KEY);
   wire key_ok = wr_key & (pwdata[15:0] == `SWT_KEY_VALUE);
   wire wr_stat = wr & (paddr == `SWT_OFF_STAT);
   wire wr_mask = wr & (paddr == `SWT_OFF_MASK);

   // ***************************************************
   // Control fields
   // ***************************************************
   wire en = ctrl_r[`SWT_CTRL_EN];
   wire enable_freeze = ctrl_r[`SWT_CTRL_FRZ];
   wire [1:0] timeout_response = ctrl_r[`SWT_CTRL_RSP_HI:`SWT_CTRL_RSP_LO];
   wire [2:0] top = ctrl_r[`SWT_CTRL_TOP_HI:`SWT_CTRL_TOP_LO];

   // ***************************************************
   // Period decode
   // ***************************************************
   always @*
   begin
      case (top)
         3'h0:
         begin
            limit = ONE_W << 21;
         end
         3'h1:
         begin
            limit = ONE_W << 22;
         end
         3'h2:
         begin
            limit = ONE_W << 23;
         end
         3'h3:
         begin
            limit = ONE_W << 24;
         end
         3'h4:
         begin
            limit = ONE_W << 25;
         end
         3'h5:
         begin
            limit = ONE_W << 26;
         end
         3'h6:
         begin
            limit = ONE_W << 29;
         end
         default:
         begin
            limit = ONE_W << 31;
         end
      endcase
   end

   // ***************************************************
   // Timeout detection
   // ***************************************************
   // Timeout on the last cycle of the period
   wire timeout = en & (cnt_r == limit - ONE_W);
   wire rsp_rst = (timeout_response == `SWT_RSP_SYSRST);
   wire rsp_fiq = (timeout_response == `SWT_RSP_FIQ);
   wire first_to = timeout & rsp_fiq & ~first_timeout_flag_r;
   wire second_to = timeout & rsp_fiq & first_timeout_flag_r;
   wire do_reset = (timeout & rsp_rst) | second_to;

   // ***************************************************
   // Control register
   // ***************************************************
   always @*
   begin
      ctrl_nxt = ctrl_r;
      if (wr_ctrl)
      begin
         ctrl_nxt[6:2] = pwdata[6:2];
         ctrl_nxt[`SWT_CTRL_FRZ] = enable_freeze | pwdata[`SWT_CTRL_FRZ];
         if (!enable_freeze)
         begin
            ctrl_nxt[`SWT_CTRL_EN] = pwdata[`SWT_CTRL_EN];
         end
      end
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_r <= `SWT_CTRL_RST;
      end
      else
      begin
         ctrl_r <= ctrl_nxt;
      end
   end

   // ***************************************************
   // Watchdog counter
   // ***************************************************
   always @*
   begin
      if (key_ok)
      begin
         cnt_nxt = {CNT_W{1'b0}};
      end
      else if (!en)
      begin
         cnt_nxt = {CNT_W{1'b0}};
      end
      else if (timeout)
      begin
         cnt_nxt = {CNT_W{1'b0}};
      end
      else
      begin
         cnt_nxt = cnt_r + ONE_W;
      end
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt_r <= {CNT_W{1'b0}};
      end
      else
      begin
         cnt_r <= cnt_nxt;
      end
   end

   // ***************************************************
   // First timeout flag
   // ***************************************************
   always @*
   begin
      first_timeout_flag_nxt = first_timeout_flag_r;
      // Set wins over a key clear in one cycle
      if (first_to)
      begin
         first_timeout_flag_nxt = 1'b1;
      end
      else if (key_ok)
      begin
         first_timeout_flag_nxt = 1'b0;
      end
      fiq_nxt = first_to | (first_timeout_flag_r & ~key_ok);
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         first_timeout_flag_r <= 1'b0;
         fast_interrupt_request <= 1'b0;
      end
      else
      begin
         first_timeout_flag_r <= first_timeout_flag_nxt;
         fast_interrupt_request <= fiq_nxt;
      end
   end

   // ***************************************************
   // System reset pulse
   // ***************************************************
   always @*
   begin
      rst_cnt_nxt = rst_cnt_r;
      if (do_reset)
      begin
         rst_cnt_nxt = RST_LEN[7:0];
      end
      else if (rst_cnt_r != 8'h00)
      begin
         rst_cnt_nxt = rst_cnt_r - 8'h01;
      end
      sys_reset_nxt = do_reset | (rst_cnt_r > 8'h01);
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rst_cnt_r <= 8'h00;
         sys_reset_req <= 1'b0;
      end
      else
      begin
         rst_cnt_r <= rst_cnt_nxt;
         sys_reset_req <= sys_reset_nxt;
      end
   end

   // ***************************************************
   // Sticky status
   // ***************************************************
   assign stat_set[`SWT_ST_FIRST] = first_to;
   assign stat_set[`SWT_ST_SECOND] = do_reset;
   assign stat_clr = {2{wr_stat}} & pwdata[1:0];
   generate
      for (gi = 0; gi < 2; gi = gi + 1)
      begin : g_stat
         always @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               stat_r[gi] <= 1'b0;
            end
            else if (stat_set[gi])
            begin
               stat_r[gi] <= 1'b1;
            end
            else if (stat_clr[gi])
            begin
               stat_r[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   // ***************************************************
   // Mask and interrupt
   // ***************************************************
   always @*
   begin
      mask_nxt = mask_r;
      if (wr_mask)
      begin
         mask_nxt = pwdata[1:0];
      end
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         mask_r <= `SWT_MASK_RST;
         irq <= 1'b0;
      end
      else
      begin
         mask_r <= mask_nxt;
         irq <= |(stat_r & mask_r);
      end
   end

   // ***************************************************
   // Read mux
   // ***************************************************
   always @*
   begin
      rdata_nxt = 32'h00000000;
      addr_ok = 1'b1;
      case (paddr)
         `SWT_OFF_CTRL:
         begin
            rdata_nxt = {25'h0000000, ctrl_r};
         end
         `SWT_OFF_KEY:
         begin
            rdata_nxt = 32'h00000000;
         end
         `SWT_OFF_STAT:
         begin
            rdata_nxt = {29'h00000000, first_timeout_flag_r, stat_r};
         end
         `SWT_OFF_MASK:
         begin
            rdata_nxt = {30'h00000000, mask_r};
         end
         default:
         begin
            addr_ok = 1'b0;
         end
      endcase
   end

   // ***************************************************
   // APB response
   // ***************************************************
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready <= setup;
         pslverr <= setup & ~addr_ok;
         if (rd)
         begin
            prdata <= rdata_nxt;
         end
      end
   end
endmodule

// file: sim/swt_watchdog_asserts.sv
// Port checker for the watchdog
`timescale 1ns/10ps
module swt_watchdog_asserts
#(
   parameter RST_LEN = 8
)
(
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire pready,
   input wire pslverr,
   input wire fast_interrupt_request,
   input wire sys_reset_req
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire key_w = psel && penable && pready && pwrite && paddr == 12'h004
      && pwdata[15:0] == 16'ha5a5;
   sequence setup_s;
      psel && !penable;
   endsequence
   a_ready_next: assert property (setup_s |=> pready)
      else $error("no ready");
   a_ready_once: assert property (pready |=> !pready)
      else $error("long ready");
   a_ready_access: assert property (pready |-> psel && penable)
      else $error("stray ready");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("stray error");
   a_bad_addr: assert property (setup_s ##0 paddr > 12'h00c |=> pslverr)
      else $error("no error");
   a_good_addr: assert property (setup_s ##0 paddr[1:0] == 2'h0 &&
      paddr <= 12'h00c |=> !pslverr) else $error("false error");
   a_rst_len: assert property ($rose(sys_reset_req) |->
      sys_reset_req [*8]) else $error("short reset");
   a_fiq_hold: assert property (fast_interrupt_request &&
      !key_w |=> fast_interrupt_request) else $error("flag lost");
endmodule
bind swt_watchdog swt_watchdog_asserts #(.RST_LEN(RST_LEN)) u_chk (.*);

// file: sim/tb_swt_watchdog.sv
// Testbench for the watchdog
`timescale 1ns/10ps
module tb_swt_watchdog;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, e;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, q;
   wire [31:0] prdata;
   wire pready, pslverr, fast_interrupt_request, sys_reset_req, irq;
   int n_mismatch = 0, cmp_count = 0, cyc = 0;
   always #50 pclk = ~pclk;
   swt_watchdog dut (.*);
   task chk(input [31:0] g, input [31:0] x);
      cmp_count++;
      if (g !== x)
      begin
         $display("wrong value at %0t got %h exp %h", $time, g, x);
         n_mismatch++;
      end
   endtask
   task rw(input bit w, input [11:0] a, input [31:0] d);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task rd(input [11:0] a, input [31:0] x, input bit ex);
      rw(0, a, 32'h0);
      chk(q, x);
      chk({31'h0, e}, {31'h0, ex});
   endtask
   task summarize;
      $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task t_reset;
      rd(12'h000, 32'h0, 0);
      rd(12'h004, 32'h0, 0);
      chk({31'h0, fast_interrupt_request}, 32'h0);
      chk({31'h0, sys_reset_req}, 32'h0);
      $display("test reset done");
   endtask
   task t_ctrl;
      rw(1, 12'h000, 32'h7d);
      rd(12'h000, 32'h7d, 0);
      rw(1, 12'h000, 32'h03);
      rw(1, 12'h000, 32'h0);
      rd(12'h000, 32'h03, 0);
      $display("test control done");
   endtask
   task t_misc;
      rw(1, 12'h004, 32'h1234);
      rw(1, 12'h004, 32'ha5a5);
      rw(1, 12'h00c, 32'h3);
      rd(12'h00c, 32'h3, 0);
      rd(12'h008, 32'h0, 0);
      chk({31'h0, irq}, 32'h0);
      chk({31'h0, fast_interrupt_request}, 32'h0);
      rd(12'h010, 32'h0, 1);
      $display("test misc done");
   endtask
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         n_mismatch++;
         summarize;
      end
   end
   initial
   begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      t_reset;
      t_ctrl;
      t_misc;
      summarize;
   end
endmodule
